// ==== logic/slk_regs.svh ====
// Register offsets, bit positions, counts and symbol codes
`ifndef SLK_REGS_SVH
`define SLK_REGS_SVH
`define SLK_OFF_SETUP 8'h00
`define SLK_OFF_HEALTH 8'h04
`define SLK_OFF_IPTR 8'h08
`define SLK_OFF_IPEND 8'h0C
`define SLK_SETUP_MASK 32'h0000_0087
`define SLK_B_TGTSEL 7
`define SLK_B_ACOMP 2
`define SLK_B_LOOP 1
`define SLK_B_SRST 0
`define SLK_B_REMERR 8
`define SLK_B_LOCERR 7
`define SLK_TIMING_MGR 1'b1
`define SLK_CLK_NS 8
`define SLK_TIMEOUT_NS 2000
`define SLK_TIMEOUT_CYC ((`SLK_TIMEOUT_NS + `SLK_CLK_NS - 1) / `SLK_CLK_NS)
`define SLK_INIT_NEED 3'h4
`define SLK_ADDR_BYTES 3'h4
`define SLK_WORD_LAST 3'h3
`define SLK_K_IDLE 8'h00
`define SLK_K_INIT 8'h01
`define SLK_K_INTR 8'h03
`define SLK_K_FLON 8'h04
`define SLK_K_FLOFF 8'h05
`define SLK_K_ERR 8'h06
`define SLK_K_SOP 8'h10
`define SLK_K_SOP_MASK 8'hF8
`endif

// ==== logic/slk_pkg.sv ====
// Types shared by the serial link port modules
package slk_pkg;
   typedef enum logic [1:0] {RX_IDLE, RX_ADDR, RX_DATA, RX_INTR} slk_rx_state_t;
   typedef enum logic [1:0] {TX_IDLE, TX_ADDR, TX_DATA} slk_tx_state_t;
   typedef logic [8:0] slk_sym_t;
endpackage : slk_pkg

// ==== logic/slk_strm_if.sv ====
// Valid/ready word stream between the port and its FIFO
`timescale 1ns/1ns
`default_nettype none
interface slk_strm_if #(
   parameter int W = 64
);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : slk_strm_if
`default_nettype wire

// ==== logic/slk_fifo.sv ====
// Synchronous word FIFO with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module slk_fifo #(
   parameter int W = 64,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst,
   slk_strm_if.snk wr,
   slk_strm_if.src rd
);
   // DEPTH must be a power of two: pointers wrap naturally
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_LEVEL = (AW+1)'(DEPTH);
   logic [W-1:0] mem [DEPTH];
   logic [AW:0] wp_reg;
   logic [AW:0] rp_reg;
   wire logic do_wr;
   wire logic do_rd;
   wire logic [AW:0] level;

   assign level = wp_reg - rp_reg;
   assign wr.ready = level != FULL_LEVEL;
   assign rd.valid = wp_reg != rp_reg;
   assign rd.data = mem[rp_reg[AW-1:0]];
   assign do_wr = wr.valid & wr.ready;
   assign do_rd = rd.valid & rd.ready;

   always_ff @(posedge clk) begin
      if (do_wr) begin
         mem[wp_reg[AW-1:0]] <= wr.data;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wp_reg <= '0;
         rp_reg <= '0;
      end else begin
         wp_reg <= wp_reg + (AW+1)'(do_wr);
         rp_reg <= rp_reg + (AW+1)'(do_rd);
      end
   end
endmodule : slk_fifo
`default_nettype wire

// ==== logic/slk_link_rx.sv ====
// Link clock edge finder and mid-period symbol sampler
`timescale 1ns/1ns
`default_nettype none
module slk_link_rx #(
   parameter int W = 9
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic link_clk,
   input wire logic [W-1:0] link_rxd,
   output logic tick,
   output logic sym_valid,
   output logic [W-1:0] sym,
   output logic [2:0] phase
);
   logic [2:0] lclk_sync_reg;
   logic [W-1:0] d_meta_reg;
   logic [W-1:0] d_sync_reg;
   logic [3:0] since_reg;
   logic armed_reg;
   wire logic rise;

   // Stage 0 feeds stage 1 only; the edge is taken between stages 1 and 2
   assign rise = lclk_sync_reg[1] & ~lclk_sync_reg[2];

   always_ff @(posedge clk) begin
      lclk_sync_reg <= {lclk_sync_reg[1:0], link_clk};
      d_meta_reg <= link_rxd;
      d_sync_reg <= d_meta_reg;
   end

   // Sample half a measured period after each rising edge, far from data changes
   always_ff @(posedge clk) begin
      if (rst) begin
         since_reg <= '0;
         armed_reg <= 1'b0;
         phase <= '0;
         tick <= 1'b0;
         sym_valid <= 1'b0;
         sym <= '0;
      end else begin
         tick <= rise;
         sym_valid <= armed_reg & (since_reg[2:0] == phase);
         if (armed_reg & (since_reg[2:0] == phase)) begin
            sym <= d_sync_reg;
         end
         if (rise) begin
            since_reg <= '0;
            armed_reg <= 1'b1;
            phase <= since_reg[3:1];
         end else begin
            since_reg <= (since_reg == 4'hF) ? since_reg : since_reg + 4'h1;
            armed_reg <= armed_reg & (since_reg[2:0] != phase);
         end
      end
   end
endmodule : slk_link_rx
`default_nettype wire

// ==== logic/slk_port.sv ====
// Serial link port: setup and health registers, link framing, inbound FIFO path
//
// Our own choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "slk_regs.svh"
// How it works
// - Target select (bit 7) set ORs interrupt packet status into the pending register when pointer bits 7:0 hold its offset.
// - Target select clear sends the status as a system write to pointer bits 31:2.
// - Setup bits 6:3 and health bits 31:28 and 19:15 read zero and ignore writes.
// - Compression off (bit 2) sends all four address bytes, else only the low bytes up to the highest changed one.
// - Loopback (bit 1) feeds transmitted symbols back into the receive path.
// - Soft reset (bit 0) holds all state machines in reset and drops the link.
// - Soft reset keeps setup, pointer and pending registers and clears health flags, the FIFO and all framing state.
// - Health bits 27:24 give the receive lane count, zero while the link is down.
// - Health bits 23:20 give the transmit lane count with the same coding.
// - Health bits 14:12 show the sample phase the receive timing logic uses now.
// - Health bit 11 always reads one.
// - A flow-on symbol from the peer stalls new outbound packets and sets bit 10 until flow-off.
// - When the inbound FIFO is full a flow-on symbol is sent and bit 9 is set.
// - Error bits 8 and 7 clear only by writing one or by soft reset; writing zero leaves them.
// - Bit 0 reads one after link start-up completes and zero before it or after a timeout.
module slk_port
   import slk_pkg::*;
#(
   parameter int LANES = 4,
   parameter int FIFO_DEPTH = 16
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic link_clk,
   input wire logic [8:0] link_rxd,
   output logic [8:0] link_txd,
   input wire logic tx_valid,
   input wire logic [31:0] tx_addr,
   input wire logic [31:0] tx_data,
   output logic tx_ready,
   output logic rx_valid,
   output logic [31:0] rx_addr,
   output logic [31:0] rx_data,
   input wire logic rx_ready,
   output logic sys_intr_wr,
   output logic [31:0] sys_intr_addr,
   output logic [31:0] sys_intr_data
);
   localparam logic [3:0] LANE_CODE = 4'(LANES);
   localparam logic [15:0] TO_CYC = 16'(`SLK_TIMEOUT_CYC);

   logic [31:0] setup_reg;
   logic [31:0] iptr_reg;
   logic [31:0] ipend_reg;
   logic wr_pend_reg;
   logic rd_pend_reg;
   logic [7:0] acc_addr_reg;
   logic acc_map_reg;
   logic [15:0] to_cnt_reg;
   logic loop_v_reg;
   slk_rx_state_t rx_st_reg;
   slk_tx_state_t tx_st_reg;
   logic [2:0] rx_idx_reg;
   logic [2:0] rx_n_reg;
   logic [31:0] rx_addr_reg;
   logic [31:0] rx_word_reg;
   logic [2:0] init_cnt_reg;
   logic stall_reg;
   logic rem_ev_reg;
   logic loc_ev_reg;
   logic push_reg;
   logic intr_ev_reg;
   logic rem_err_reg;
   logic loc_err_reg;
   logic outbound_flow_asserted_reg;
   logic flow_sent_reg;
   logic err_pend_reg;
   logic hold_full_reg;
   logic [31:0] hold_addr_reg;
   logic [31:0] hold_data_reg;
   logic [31:0] cur_addr_reg;
   logic [31:0] cur_data_reg;
   logic [2:0] cur_n_reg;
   logic [2:0] tx_idx_reg;
   logic [31:0] last_addr_reg;
   wire logic st_rst;
   wire logic tick;
   wire logic samp_v;
   wire slk_sym_t samp_sym;
   wire logic [2:0] phase;
   wire logic timed_out;
   wire logic link_up;
   wire logic rx_v;
   wire slk_sym_t rx_s;
   wire logic rx_is_sop;
   wire logic [31:0] adiff;
   wire logic [2:0] tx_n;
   wire logic ctl_flow;
   wire logic start;
   wire logic acc;
   wire logic hold_next;
   wire logic addr_phase;
   wire logic wr_setup;
   wire logic wr_health;
   wire logic wr_iptr;
   wire logic wr_ipend;
   wire logic intr_local;
   wire logic [31:0] health;
   wire logic [31:0] rd_mux;
   wire logic [3:0] lane_now;

   slk_strm_if #(.W(64)) in_q ();
   slk_strm_if #(.W(64)) out_q ();

   // Soft reset never reaches setup, pointer or pending registers
   assign st_rst = rst | setup_reg[`SLK_B_SRST];

   slk_link_rx #(.W(9)) u_link_rx (
      .clk(sys_clk),
      .rst(st_rst),
      .link_clk(link_clk),
      .link_rxd(link_rxd),
      .tick(tick),
      .sym_valid(samp_v),
      .sym(samp_sym),
      .phase(phase)
   );

   slk_fifo #(.W(64), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(sys_clk),
      .rst(st_rst),
      .wr(in_q.snk),
      .rd(out_q.src)
   );

   // Register bus decode
   assign addr_phase = hsel & hready & htrans[1];
   assign wr_setup = wr_pend_reg & acc_map_reg & (acc_addr_reg == `SLK_OFF_SETUP);
   assign wr_health = wr_pend_reg & acc_map_reg & (acc_addr_reg == `SLK_OFF_HEALTH);
   assign wr_iptr = wr_pend_reg & acc_map_reg & (acc_addr_reg == `SLK_OFF_IPTR);
   assign wr_ipend = wr_pend_reg & acc_map_reg & (acc_addr_reg == `SLK_OFF_IPEND);
   assign lane_now = link_up ? LANE_CODE : 4'h0;
   assign health = {4'h0, lane_now, lane_now, 5'h00, phase, `SLK_TIMING_MGR, stall_reg,
                    outbound_flow_asserted_reg, rem_err_reg, loc_err_reg, 6'h00, link_up};
   assign rd_mux = !acc_map_reg ? 32'h0000_0000 :
                   (acc_addr_reg == `SLK_OFF_SETUP) ? setup_reg :
                   (acc_addr_reg == `SLK_OFF_HEALTH) ? health :
                   (acc_addr_reg == `SLK_OFF_IPTR) ? iptr_reg :
                   (acc_addr_reg == `SLK_OFF_IPEND) ? ipend_reg : 32'h0000_0000;

   // Reads take one wait state so a write just before them is already applied
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wr_pend_reg <= 1'b0;
         rd_pend_reg <= 1'b0;
         acc_addr_reg <= '0;
         acc_map_reg <= 1'b0;
         hreadyout <= 1'b1;
         hrdata <= '0;
         hresp <= 1'b0;
      end else begin
         wr_pend_reg <= addr_phase & hwrite;
         rd_pend_reg <= addr_phase & ~hwrite;
         if (addr_phase) begin
            acc_addr_reg <= haddr[7:0];
            acc_map_reg <= ~|haddr[31:8] & ~|haddr[1:0];
         end
         hreadyout <= ~(addr_phase & ~hwrite);
         if (rd_pend_reg) begin
            hrdata <= rd_mux;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         setup_reg <= '0;
         iptr_reg <= '0;
      end else begin
         if (wr_setup) begin
            setup_reg <= hwdata & `SLK_SETUP_MASK;
         end
         if (wr_iptr) begin
            iptr_reg <= hwdata;
         end
      end
   end

   // Interrupt packet delivery
   assign intr_local = intr_ev_reg & setup_reg[`SLK_B_TGTSEL] & (iptr_reg[7:0] == `SLK_OFF_IPEND);

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ipend_reg <= '0;
      end else begin
         ipend_reg <= (ipend_reg & ~(wr_ipend ? hwdata : 32'h0000_0000)) |
                      (intr_local ? rx_word_reg : 32'h0000_0000);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (st_rst) begin
         sys_intr_wr <= 1'b0;
         sys_intr_addr <= '0;
         sys_intr_data <= '0;
      end else begin
         sys_intr_wr <= intr_ev_reg & ~setup_reg[`SLK_B_TGTSEL];
         if (intr_ev_reg & ~setup_reg[`SLK_B_TGTSEL]) begin
            sys_intr_addr <= {iptr_reg[31:2], 2'b00};
            sys_intr_data <= rx_word_reg;
         end
      end
   end

   // Link supervision
   assign timed_out = to_cnt_reg == TO_CYC;
   assign link_up = init_cnt_reg == `SLK_INIT_NEED;

   always_ff @(posedge sys_clk) begin
      if (st_rst | tick) begin
         to_cnt_reg <= '0;
      end else if (!timed_out) begin
         to_cnt_reg <= to_cnt_reg + 16'h0001;
      end
   end

   assign rx_v = setup_reg[`SLK_B_LOOP] ? loop_v_reg : samp_v;
   assign rx_s = setup_reg[`SLK_B_LOOP] ? link_txd : samp_sym;
   assign rx_is_sop = (rx_s[7:0] & `SLK_K_SOP_MASK) == `SLK_K_SOP;

   // Receive framing
   always_ff @(posedge sys_clk) begin
      rem_ev_reg <= 1'b0;
      loc_ev_reg <= push_reg & ~in_q.ready;
      push_reg <= 1'b0;
      intr_ev_reg <= 1'b0;
      if (st_rst | timed_out) begin
         rx_st_reg <= RX_IDLE;
         rx_idx_reg <= '0;
         rx_n_reg <= '0;
         init_cnt_reg <= '0;
         stall_reg <= 1'b0;
         if (st_rst) begin
            rx_addr_reg <= '0;
            rx_word_reg <= '0;
         end
      end else if (rx_v & rx_s[8]) begin
         rx_idx_reg <= '0;
         rx_st_reg <= RX_IDLE;
         loc_ev_reg <= rx_st_reg != RX_IDLE;
         if (rx_s[7:0] == `SLK_K_INIT && !link_up) begin
            init_cnt_reg <= init_cnt_reg + 3'h1;
         end
         if (rx_s[7:0] == `SLK_K_FLON) begin
            stall_reg <= 1'b1;
         end
         if (rx_s[7:0] == `SLK_K_FLOFF) begin
            stall_reg <= 1'b0;
         end
         rem_ev_reg <= rx_s[7:0] == `SLK_K_ERR;
         if (rx_s[7:0] == `SLK_K_INTR) begin
            rx_st_reg <= RX_INTR;
         end
         if (rx_is_sop) begin
            rx_n_reg <= rx_s[2:0];
            rx_st_reg <= (rx_s[2:0] == 3'h0) ? RX_DATA : RX_ADDR;
            if (rx_s[2:0] > `SLK_ADDR_BYTES) begin
               loc_ev_reg <= 1'b1;
               rx_st_reg <= RX_IDLE;
            end
         end
      end else if (rx_v) begin
         rx_idx_reg <= rx_idx_reg + 3'h1;
         case (rx_st_reg)
            RX_IDLE: begin
               loc_ev_reg <= 1'b1;
               rx_idx_reg <= '0;
            end
            RX_ADDR: begin
               rx_addr_reg[{rx_idx_reg[1:0], 3'b000} +: 8] <= rx_s[7:0];
               if (rx_idx_reg + 3'h1 == rx_n_reg) begin
                  rx_st_reg <= RX_DATA;
                  rx_idx_reg <= '0;
               end
            end
            RX_DATA, RX_INTR: begin
               rx_word_reg[{rx_idx_reg[1:0], 3'b000} +: 8] <= rx_s[7:0];
               if (rx_idx_reg == `SLK_WORD_LAST) begin
                  push_reg <= rx_st_reg == RX_DATA;
                  intr_ev_reg <= rx_st_reg == RX_INTR;
                  rx_st_reg <= RX_IDLE;
               end
            end
            default: rx_st_reg <= RX_IDLE;
         endcase
      end
   end

   assign in_q.valid = push_reg;
   assign in_q.data = {rx_addr_reg, rx_word_reg};

   // Health flags; a set in the same cycle as a clear wins
   always_ff @(posedge sys_clk) begin
      if (st_rst) begin
         rem_err_reg <= 1'b0;
         loc_err_reg <= 1'b0;
         outbound_flow_asserted_reg <= 1'b0;
      end else begin
         rem_err_reg <= rem_ev_reg | (rem_err_reg & ~(wr_health & hwdata[`SLK_B_REMERR]));
         loc_err_reg <= loc_ev_reg | (loc_err_reg & ~(wr_health & hwdata[`SLK_B_LOCERR]));
         outbound_flow_asserted_reg <= ~in_q.ready;
      end
   end

   // Inbound words to the user, through one output stage
   assign out_q.ready = ~rx_valid | rx_ready;

   always_ff @(posedge sys_clk) begin
      if (st_rst) begin
         rx_valid <= 1'b0;
         rx_addr <= '0;
         rx_data <= '0;
      end else if (out_q.ready) begin
         rx_valid <= out_q.valid;
         rx_addr <= out_q.data[63:32];
         rx_data <= out_q.data[31:0];
      end
   end

   // Outbound holding slot
   assign acc = tx_valid & tx_ready;
   assign hold_next = acc | (hold_full_reg & ~start);

   always_ff @(posedge sys_clk) begin
      if (st_rst) begin
         hold_full_reg <= 1'b0;
         tx_ready <= 1'b0;
         hold_addr_reg <= '0;
         hold_data_reg <= '0;
      end else begin
         hold_full_reg <= hold_next;
         tx_ready <= ~hold_next;
         if (acc) begin
            hold_addr_reg <= tx_addr;
            hold_data_reg <= tx_data;
         end
      end
   end

   // Transmit framing
   assign adiff = hold_addr_reg ^ last_addr_reg;
   assign tx_n = setup_reg[`SLK_B_ACOMP] ? `SLK_ADDR_BYTES :
                 (|adiff[31:24]) ? 3'h4 :
                 (|adiff[23:16]) ? 3'h3 :
                 (|adiff[15:8]) ? 3'h2 :
                 (|adiff[7:0]) ? 3'h1 : 3'h0;
   assign ctl_flow = outbound_flow_asserted_reg != flow_sent_reg;
   assign start = tick & link_up & (tx_st_reg == TX_IDLE) & ~ctl_flow & ~err_pend_reg &
                  hold_full_reg & ~stall_reg;

   always_ff @(posedge sys_clk) begin
      loop_v_reg <= tick & ~st_rst;
      if (st_rst) begin
         link_txd <= {1'b1, `SLK_K_IDLE};
         tx_st_reg <= TX_IDLE;
         tx_idx_reg <= '0;
         flow_sent_reg <= 1'b0;
         err_pend_reg <= 1'b0;
         last_addr_reg <= '0;
         cur_addr_reg <= '0;
         cur_data_reg <= '0;
         cur_n_reg <= '0;
      end else begin
         if (tick) begin
            tx_idx_reg <= tx_idx_reg + 3'h1;
            if (!link_up) begin
               link_txd <= {1'b1, `SLK_K_INIT};
               tx_st_reg <= TX_IDLE;
            end else begin
               case (tx_st_reg)
                  TX_IDLE: begin
                     tx_idx_reg <= '0;
                     if (ctl_flow) begin
                        link_txd <= {1'b1, outbound_flow_asserted_reg ? `SLK_K_FLON : `SLK_K_FLOFF};
                        flow_sent_reg <= outbound_flow_asserted_reg;
                     end else if (err_pend_reg) begin
                        link_txd <= {1'b1, `SLK_K_ERR};
                        err_pend_reg <= 1'b0;
                     end else if (start) begin
                        link_txd <= {1'b1, `SLK_K_SOP | {5'h00, tx_n}};
                        cur_addr_reg <= hold_addr_reg;
                        cur_data_reg <= hold_data_reg;
                        cur_n_reg <= tx_n;
                        tx_st_reg <= (tx_n == 3'h0) ? TX_DATA : TX_ADDR;
                     end else begin
                        link_txd <= {1'b1, `SLK_K_IDLE};
                     end
                  end
                  TX_ADDR: begin
                     link_txd <= {1'b0, cur_addr_reg[{tx_idx_reg[1:0], 3'b000} +: 8]};
                     if (tx_idx_reg + 3'h1 == cur_n_reg) begin
                        tx_st_reg <= TX_DATA;
                        tx_idx_reg <= '0;
                     end
                  end
                  TX_DATA: begin
                     link_txd <= {1'b0, cur_data_reg[{tx_idx_reg[1:0], 3'b000} +: 8]};
                     if (tx_idx_reg == `SLK_WORD_LAST) begin
                        tx_st_reg <= TX_IDLE;
                        last_addr_reg <= cur_addr_reg;
                     end
                  end
                  default: tx_st_reg <= TX_IDLE;
               endcase
            end
         end
         // Placed last so a fresh local error is never lost to the send above
         if (loc_ev_reg) begin
            err_pend_reg <= 1'b1;
         end
      end
   end
endmodule : slk_port
`default_nettype wire

// ==== verification/slk_port_checker.sv ====
// Pin-level assertions for the serial link port
`timescale 1ns/1ns
`default_nettype none
module slk_port_checker (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [8:0] link_txd,
   input wire logic tx_ready,
   input wire logic rx_valid,
   input wire logic rx_ready,
   input wire logic [31:0] rx_data,
   input wire logic sys_intr_wr,
   input wire logic [31:0] sys_intr_addr
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   logic wr_reg;
   logic srst_reg;
   logic tgt_reg;
   logic [5:0] cnt_reg;
   wire logic take = hsel && hready && htrans[1];
   wire logic setup_wr = take && hwrite && haddr == 32'h0000_0000;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wr_reg <= 1'b0;
         srst_reg <= 1'b0;
         tgt_reg <= 1'b0;
         cnt_reg <= 6'h00;
      end else begin
         wr_reg <= setup_wr;
         if (wr_reg) begin
            srst_reg <= hwdata[0];
            tgt_reg <= hwdata[7];
         end
         cnt_reg <= !srst_reg ? 6'h00 : cnt_reg + {5'h00, cnt_reg != 6'h3F};
      end
   end
   a_bus_okay: assert property (!hresp)
      else $error("hresp not OKAY");
   a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait wrong");
   a_srst_quiet: assert property (cnt_reg > 6'h28 |-> link_txd == 9'h100 && !rx_valid && !sys_intr_wr)
      else $error("link active in srst");
   a_srst_no_tx: assert property (cnt_reg > 6'h02 |-> !tx_ready)
      else $error("tx slot open in srst");
   a_intr_pulse: assert property (sys_intr_wr |=> !sys_intr_wr)
      else $error("intr write too long");
   a_intr_word: assert property (sys_intr_wr |-> sys_intr_addr[1:0] == 2'b00)
      else $error("intr addr unaligned");
   a_intr_local: assert property (tgt_reg && $past(tgt_reg, 4) |-> !sys_intr_wr)
      else $error("local intr went out");
   a_rx_hold: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
      else $error("rx word dropped");
endmodule : slk_port_checker
bind slk_port slk_port_checker u_chk (.*);
`default_nettype wire

// ==== verification/slk_peer.sv ====
// Behavioural peer port at the far end of the link
`timescale 1ns/1ns
`default_nettype none
module slk_peer (
   output logic link_clk,
   output logic [8:0] link_rxd,
   input wire logic [8:0] link_txd
);
   logic run = 1'b0;
   logic [8:0] q[$];
   logic [8:0] seen[$];
   initial begin
      link_clk = 1'b0;
      link_rxd = 9'h100;
      #3;
      forever begin
         if (run) begin
            #62 link_clk = 1'b1;
            #63 link_clk = 1'b0;
         end else begin
            #8 link_rxd = ~link_rxd;
         end
      end
   end
   always @(posedge link_clk) link_rxd <= (q.size() != 0) ? q.pop_front() : 9'h100;
   always @(negedge link_clk) seen.push_back(link_txd);
   task send(input logic [8:0] s);
      q.push_back(s);
   endtask : send
endmodule : slk_peer
`default_nettype wire

// ==== verification/slk_port_tb.sv ====
// Self-checking bench for the serial link port
`timescale 1ns/1ns
`default_nettype none
module slk_port_tb;
   logic sys_clk, rst, hsel, hwrite, tx_valid, rx_ready;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, tx_addr, tx_data, r, a, d, ia, id;
   wire logic hreadyout, hresp, tx_ready, rx_valid, sys_intr_wr, link_clk;
   wire logic [31:0] hrdata, rx_addr, rx_data, sys_intr_addr, sys_intr_data;
   wire logic [8:0] link_rxd, link_txd;
   int n_fail = 0, check_count = 0, ni = 0, k, i;
   logic [63:0] rxq[$];
   slk_port DUT (.*, .hready(hreadyout));
   slk_peer peer (.*);
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      if (rx_valid && rx_ready) rxq.push_back({rx_addr, rx_data});
      if (sys_intr_wr) begin
         ia = sys_intr_addr;
         id = sys_intr_data;
         ni++;
      end
   end
   function logic [31:0] health(input logic up, input logic [2:0] ph, input logic [3:0] fl);
      return {4'h0, up ? 8'h44 : 8'h00, 5'h00, ph, 1'b1, fl, 6'h00, up};
   endfunction : health
   function int find_sop();
      find_sop = -1;
      foreach (peer.seen[j]) if (find_sop < 0 && peer.seen[j][8:3] == 6'h22) find_sop = j;
   endfunction : find_sop
   function logic [31:0] has(input logic [8:0] s);
      has = 0;
      foreach (peer.seen[j]) if (peer.seen[j] === s) has = 1;
   endfunction : has
   task results;
      $display("checks %0d fails %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : results
   task give_up;
      n_fail++;
      results();
   endtask : give_up
   task chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR t=%0t seen=%h expected=%h", $time, got, exp);
      end
   endtask : chk
   task hold_rdy;
      for (k = 0; k == 0 || !hreadyout; k++) begin
         if (k > 50) give_up();
         @(posedge sys_clk);
      end
      r = hrdata;
   endtask : hold_rdy
   task bus(input logic w, input logic [31:0] ad, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= ad;
      hwrite <= w;
      hold_rdy();
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      hold_rdy();
   endtask : bus
   task drain;
      for (k = 0; peer.q.size() != 0; k++) begin
         if (k > 20000) give_up();
         @(posedge sys_clk);
      end
      repeat (40) @(posedge sys_clk);
   endtask : drain
   task pkt(input logic [8:0] c, input logic [31:0] x, input logic [31:0] y, input int na);
      peer.send(c);
      for (int j = 0; j < na; j++) peer.send({1'b0, x[8*j +: 8]});
      for (int j = 0; j < 4; j++) peer.send({1'b0, y[8*j +: 8]});
   endtask : pkt
   task tx_sop(input logic [31:0] ta);
      peer.seen.delete();
      tx_valid <= 1'b1;
      tx_addr <= ta;
      tx_data <= $urandom;
      for (k = 0; k == 0 || !tx_ready; k++) begin
         if (k > 5000) give_up();
         @(posedge sys_clk);
      end
      tx_valid <= 1'b0;
   endtask : tx_sop
   task sop_wait;
      for (k = 0; find_sop() < 0; k++) begin
         if (k > 3000) give_up();
         @(posedge sys_clk);
      end
      repeat (80) @(posedge sys_clk);
      i = find_sop();
   endtask : sop_wait
   initial begin
      void'($urandom(15));
      rst = 1'b1;
      {hsel, hwrite, tx_valid, htrans, haddr, hwdata, tx_addr, tx_data} = '0;
      hsize = 3'h2;
      rx_ready = 1'b1;
      repeat (10) @(posedge sys_clk);
      rst <= 1'b0;
      bus(0, 32'h0, 0);
      chk(r, 32'h0);
      bus(0, 32'h4, 0);
      chk(r & 32'hFFFF_8FFF, health(0, 0, 0));
      bus(0, 32'h10, 0);
      chk(r, 32'h0);
      for (i = 0; i < 4; i++) begin
         a = $urandom;
         bus(1, 32'h0, a);
         bus(0, 32'h0, 0);
         chk(r, a & 32'h87);
      end
      bus(1, 32'h0, 32'h4);
      $display("test registers done");
      peer.run = 1'b1;
      repeat (4) peer.send(9'h101);
      drain();
      bus(0, 32'h4, 0);
      chk(r, health(1, 7, 0));
      rx_ready <= 1'b0;
      peer.seen.delete();
      for (i = 0; i < 17; i++) pkt(9'h114, $urandom, 32'(i), 4);
      drain();
      bus(0, 32'h4, 0);
      chk(r, health(1, 7, 4'h4));
      chk(has(9'h104), 1);
      peer.send(9'h055);
      peer.send(9'h106);
      drain();
      bus(1, 32'h4, 0);
      bus(0, 32'h4, 0);
      chk(32'(r[8:7]), 3);
      bus(1, 32'h4, 32'h180);
      bus(0, 32'h4, 0);
      chk(32'(r[8:7]), 0);
      peer.seen.delete();
      rx_ready <= 1'b1;
      repeat (80) @(posedge sys_clk);
      bus(0, 32'h4, 0);
      chk(32'(r[9]), 0);
      chk(has(9'h105), 1);
      chk(32'(rxq.size()), 17);
      chk(rxq[16][31:0], 32'h10);
      $display("test inbound flow done");
      peer.send(9'h104);
      drain();
      bus(0, 32'h4, 0);
      chk(32'(r[10]), 1);
      bus(1, 32'h0, 32'h84);
      a = $urandom;
      tx_sop(a);
      repeat (320) @(posedge sys_clk);
      chk(32'(find_sop()), 32'hFFFF_FFFF);
      peer.send(9'h105);
      sop_wait();
      chk(32'(peer.seen[i]), 32'h114);
      chk({peer.seen[i+4][7:0], peer.seen[i+3][7:0], peer.seen[i+2][7:0],
         peer.seen[i+1][7:0]}, a);
      bus(1, 32'h0, 32'h80);
      tx_sop(a);
      sop_wait();
      chk(32'(peer.seen[i]), 32'h110);
      $display("test outbound done");
      a = $urandom;
      bus(1, 32'h8, a);
      bus(1, 32'h0, 32'h0);
      d = $urandom;
      pkt(9'h103, 0, d, 0);
      drain();
      chk(ia, {a[31:2], 2'b00});
      chk(id, d);
      bus(1, 32'h0, 32'h80);
      bus(1, 32'h8, 32'hC);
      d = $urandom;
      pkt(9'h103, 0, d, 0);
      drain();
      bus(0, 32'hC, 0);
      chk(r, d);
      chk(32'(ni), 1);
      $display("test interrupts done");
      bus(1, 32'h0, 32'h85);
      repeat (80) @(posedge sys_clk);
      bus(0, 32'h0, 0);
      chk(r, 32'h85);
      bus(0, 32'h8, 0);
      chk(r, 32'hC);
      bus(0, 32'h4, 0);
      chk(r & 32'hFFFF_8FFF, health(0, 0, 0));
      bus(1, 32'h0, 32'h86);
      repeat (200) @(posedge sys_clk);
      bus(0, 32'h4, 0);
      chk(32'(r[0]), 1);
      peer.run = 1'b0;
      repeat (300) @(posedge sys_clk);
      bus(0, 32'h4, 0);
      chk(32'(r[0]), 0);
      $display("test soft reset done");
      results();
   end
endmodule : slk_port_tb
`default_nettype wire
